// ---- tb/duty_capture.sv ----
// Receiving host model: times one duty-cycle output, decodes it.
// Assumes the waveform is synchronous to clk_in and rises once a period.
`timescale 1ns/1ps

module duty_capture #(
  parameter int unsigned PERIOD_CYCLES = 16
) (
  input wire logic clk_in,
  input wire logic pulse_in,
  input wire logic clear_in,
  output logic [15:0] high_len_out,
  output logic [15:0] period_len_out,
  output real rh_pct_out,
  output real temp_c_out
);
  logic prev;
  logic [15:0] since;
  logic [15:0] high_cnt;

  // Time rise to rise and rise to fall; constant low leaves values cleared
  always @(posedge clk_in) begin
    prev <= pulse_in;
    if (clear_in) begin
      high_len_out <= 16'h0000;
      period_len_out <= 16'h0000;
    end else if (pulse_in && !prev) begin
      period_len_out <= since;
      since <= 16'h0001;
      high_cnt <= 16'h0001;
    end else begin
      since <= since + 16'h0001;
      if (pulse_in) high_cnt <= high_cnt + 16'h0001;
      if (!pulse_in && prev) high_len_out <= high_cnt;
    end
  end

  // Decode without clamping, so readings beyond 0..100 pass
  always_comb begin
    rh_pct_out = -6.0 + 125.0 * high_len_out / PERIOD_CYCLES;
    temp_c_out = -46.85 + 175.72 * high_len_out / PERIOD_CYCLES;
  end
endmodule // duty_capture

// ---- tb/tb_dual_duty_output.sv ----
// Self-checking bench for the dual duty-cycle output block.
// Assumes short interval and period parameters to keep the run brief.
`timescale 1ns/1ps

module tb_dual_duty_output;
  import duty_pkg::*;
  localparam int unsigned P = 16;
  localparam int unsigned MEAS = 64;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic select_in = 1'b1;
  meas_pair_t result_in = '0;
  logic first_pulse_output_out;
  logic second_pulse_output_out;
  logic clear = 1'b0;
  logic [15:0] hi1, hi2, per1, per2;
  real rh1, rh2, tc1, tc2;
  int errors = 0;
  int tests_run = 0;

  dual_duty_output #(.MEAS_INTERVAL_CYCLES(MEAS), .PERIOD_CYCLES(P)) dut_u (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .select_in(select_in),
    .result_in(result_in),
    .first_pulse_output_out(first_pulse_output_out),
    .second_pulse_output_out(second_pulse_output_out)
  );
  duty_capture #(.PERIOD_CYCLES(P)) cap1_u (.clk_in(core_clk_in),
    .pulse_in(first_pulse_output_out), .clear_in(clear),
    .high_len_out(hi1), .period_len_out(per1),
    .rh_pct_out(rh1), .temp_c_out(tc1));
  duty_capture #(.PERIOD_CYCLES(P)) cap2_u (.clk_in(core_clk_in),
    .pulse_in(second_pulse_output_out), .clear_in(clear),
    .high_len_out(hi2), .period_len_out(per2),
    .rh_pct_out(rh2), .temp_c_out(tc2));

  // 10 MHz core clock
  initial begin
    forever #50 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Apply inputs at a falling edge, then let two intervals and three periods pass
  task automatic apply(input logic sel, input code_t hum, input code_t tmp);
    @(negedge core_clk_in);
    select_in = sel;
    result_in = '{humidity: hum, temperature: tmp};
    clear = 1'b1;
    @(negedge core_clk_in);
    clear = 1'b0;
    repeat (2 * MEAS + 3 * P) @(negedge core_clk_in);
  endtask

  // Sweep duties across the range; each pair sampled together
  task automatic t_linear();
    for (int i = 1; i < 15; i++) begin
      apply(1'b1, code_t'((i << 12) | 16'h0ABC), code_t'((15 - i) << 12));
      chk(hi1, 32'(i));
      chk(hi2, 32'(15 - i));
      chk(per1, 32'(P));
      chk(per2, 32'(P));
      if (i == 8) begin
        chk($rtoi(rh1 * 100.0 + 0.5), 32'h00001612);
        chk($rtoi(tc2 * 100.0 + 0.5), 32'h00000BBB);
      end
    end
    $display("test linear done");
  endtask

  // Select low swaps which measurement each output carries
  task automatic t_swap();
    apply(1'b0, 16'h5000, 16'hA000);
    chk(hi1, 32'h0000000A);
    chk(hi2, 32'h00000005);
    $display("test swap done");
  endtask

  // Full-scale and zero codes, both select levels
  task automatic t_edges();
    for (int s = 0; s < 2; s++) begin
      apply(s[0], 16'hFFFF, 16'h0000);
      for (int c = 0; c < 2 * P; c++) begin
        @(negedge core_clk_in);
        chk(s[0] ? second_pulse_output_out : first_pulse_output_out,
          32'h0);
      end
      chk(s[0] ? hi1 : hi2, 32'h0000000F);
      chk($rtoi((s[0] ? rh1 : rh2) * 100.0 + 0.5), 32'h00002B6F);
    end
    $display("test edges done");
  endtask

  // Mid-run reset: outputs drop at once, and the first sample after
  // release is taken straight away, well before a whole interval passes
  task automatic t_reset();
    @(negedge core_clk_in);
    rst_n_in = 1'b0;
    select_in = 1'b1;
    result_in = '{humidity: 16'h3000, temperature: 16'hC000};
    clear = 1'b1;
    repeat (3) @(negedge core_clk_in);
    chk(first_pulse_output_out, 32'h0);
    chk(second_pulse_output_out, 32'h0);
    rst_n_in = 1'b1;
    clear = 1'b0;
    repeat (3 * P + 8) @(negedge core_clk_in);
    chk(hi1, 32'h00000003);
    chk(hi2, 32'h0000000C);
    $display("test reset done");
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard: the tests need roughly 3150 cycles
  initial begin
    #(100 * 20000);
    errors++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    t_linear();
    t_swap();
    t_edges();
    t_reset();
    report_and_stop();
  end
endmodule // tb_dual_duty_output

// ---- verilog/dual_duty_output.sv ----
// Top of the dual duty-cycle output block: samples the two results each
// interval and routes them to two waveform outputs under a select pin.
// Assumes results come from logic on core_clk_in; select is an async pin.
`timescale 1ns/1ps
`include "duty_consts.svh"

// Summary of operation
// - A new humidity and temperature result is taken every second and each drives a duty-cycle waveform.
// - Select high puts humidity on the first output and temperature on the second, low swaps them.
// - Each output's duty is a linear function of its result between the smallest and largest duty.
// - Humidity percent equals minus six plus 125 times the duty fraction, decoded the same way outside.
// - Temperature in Celsius equals minus 46.85 plus 175.72 times the duty fraction, decoded likewise.
// - Humidity is not clamped, so readings a little below 0 or above 100 percent pass through.
module dual_duty_output #(
  parameter int unsigned MEAS_INTERVAL_CYCLES = `MEAS_INTERVAL_CYCLES,
  parameter int unsigned PERIOD_CYCLES = `PWM_PERIOD_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic select_in,
  input wire duty_pkg::meas_pair_t result_in,
  output logic first_pulse_output_out,
  output logic second_pulse_output_out
);
  import duty_pkg::*;

  localparam int TW = $clog2(MEAS_INTERVAL_CYCLES);
  localparam logic [TW-1:0] RELOAD = TW'(MEAS_INTERVAL_CYCLES - 1);

  // The interval counter needs at least two states
  if (MEAS_INTERVAL_CYCLES < 2) begin : g_bad_interval
    $error("dual_duty_output: MEAS_INTERVAL_CYCLES must be at least 2");
  end

  // --------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------
  logic [1:0] rst_pipe;
  wire logic rst_n_sync;

  // Asserts at once, releases two edges later so all flops leave together
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n_sync = rst_pipe[1];

  // --------------------------------------------------------------------
  // Select pin synchroniser
  // --------------------------------------------------------------------
  logic sel_meta;
  logic sel_sync;

  // Static strap in practice, but still double-flopped; a floating pin
  // would make the assignment wander, which the board must prevent
  always_ff @(posedge core_clk_in or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
    end else begin
      sel_meta <= select_in;
      sel_sync <= sel_meta;
    end
  end

  // --------------------------------------------------------------------
  // Output assignment mode
  // --------------------------------------------------------------------
  assign_t mode;
  wire assign_t next_mode;

  assign next_mode = sel_sync ? ASSIGN_HUM_FIRST : ASSIGN_TEMP_FIRST;

  // Registered so both channel inputs switch on the same edge
  always_ff @(posedge core_clk_in or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      mode <= ASSIGN_TEMP_FIRST;
    end else begin
      mode <= next_mode;
    end
  end

  // --------------------------------------------------------------------
  // Measurement interval timer
  // --------------------------------------------------------------------
  logic [TW-1:0] timer;
  wire logic sample_tick;
  wire logic [TW-1:0] next_timer;

  // Timer resets to zero so a result is taken straight after reset,
  // rather than showing a zero code for the first whole second
  assign sample_tick = (timer == '0);
  assign next_timer = sample_tick ? RELOAD : TW'(timer - 1'b1);

  always_ff @(posedge core_clk_in or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      timer <= '0;
    end else begin
      timer <= next_timer;
    end
  end

  // --------------------------------------------------------------------
  // Held result pair
  // --------------------------------------------------------------------
  meas_pair_t held;
  wire meas_pair_t next_held;

  // Both results are taken in one cycle so they always belong together
  assign next_held = sample_tick ? result_in : held;

  always_ff @(posedge core_clk_in or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      held <= '{humidity: `RESET_CODE, temperature: `RESET_CODE};
    end else begin
      held <= next_held;
    end
  end

  // --------------------------------------------------------------------
  // Routing to channels
  // --------------------------------------------------------------------
  wire code_t first_code;
  wire code_t second_code;
  wire logic hum_first;

  // Routing sits ahead of the channels, so a select change lands at the
  // next period start instead of splicing two waveforms mid-pulse
  assign hum_first = (mode == ASSIGN_HUM_FIRST);
  assign first_code = hum_first ? held.humidity : held.temperature;
  assign second_code = hum_first ? held.temperature : held.humidity;

  // --------------------------------------------------------------------
  // Waveform channels; both reset together and stay in phase
  // --------------------------------------------------------------------
  duty_channel #(
    .PERIOD_CYCLES(PERIOD_CYCLES)
  ) u_first (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_sync),
    .code_in(first_code),
    .pulse_out(first_pulse_output_out)
  );

  duty_channel #(
    .PERIOD_CYCLES(PERIOD_CYCLES)
  ) u_second (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n_sync),
    .code_in(second_code),
    .pulse_out(second_pulse_output_out)
  );

  // --------------------------------------------------------------------
  // Checking helpers: cycles since the last sample
  // --------------------------------------------------------------------
  logic [TW-1:0] gap;
  logic seen_tick;

  always_ff @(posedge core_clk_in or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      gap <= '0;
      seen_tick <= 1'b0;
    end else begin
      gap <= sample_tick ? '0 : TW'(gap + 1'b1);
      seen_tick <= seen_tick | sample_tick;
    end
  end

  sequence s_tick;
    sample_tick;
  endsequence

  sequence s_sel_high_settled;
    sel_sync ##1 1'b1;
  endsequence

  sequence s_sel_low_settled;
    !sel_sync ##1 1'b1;
  endsequence

  property p_sample_period;
    @(posedge core_clk_in) disable iff (!rst_n_sync)
    (s_tick and seen_tick) |-> (gap == RELOAD);
  endproperty
  a_sample_period: assert property (p_sample_period)
    else $error("results not taken once per interval");

  property p_sample_capture;
    @(posedge core_clk_in) disable iff (!rst_n_sync)
    s_tick |=> (held == $past(result_in));
  endproperty
  a_sample_capture: assert property (p_sample_capture)
    else $error("held pair differs from sampled results");

  property p_sample_hold;
    @(posedge core_clk_in) disable iff (!rst_n_sync)
    !sample_tick |=> $stable(held);
  endproperty
  a_sample_hold: assert property (p_sample_hold)
    else $error("held pair changed between samples");

  property p_first_sample;
    @(posedge core_clk_in) disable iff (!rst_n_sync)
    $rose(rst_n_sync) |-> sample_tick;
  endproperty
  a_first_sample: assert property (p_first_sample)
    else $error("no sample taken right after reset");

  property p_route_high;
    @(posedge core_clk_in) disable iff (!rst_n_sync)
    s_sel_high_settled |-> (first_code == held.humidity) &&
      (second_code == held.temperature);
  endproperty
  a_route_high: assert property (p_route_high)
    else $error("select high routing wrong");

  property p_route_low;
    @(posedge core_clk_in) disable iff (!rst_n_sync)
    s_sel_low_settled |-> (first_code == held.temperature) &&
      (second_code == held.humidity);
  endproperty
  a_route_low: assert property (p_route_low)
    else $error("select low routing wrong");

endmodule // dual_duty_output

// ---- verilog/duty_channel.sv ----
// One duty-cycle output channel: period counter, shadowed duty, output flop.
// Assumes a reset already synchronised to clk_in and a code from clk_in logic.
`timescale 1ns/1ps
`include "duty_consts.svh"

module duty_channel #(
  parameter int unsigned PERIOD_CYCLES = `PWM_PERIOD_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire duty_pkg::code_t code_in,
  output logic pulse_out
);
  import duty_pkg::*;

  localparam int CW = $clog2(PERIOD_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(PERIOD_CYCLES - 1);

  // Shift-only scaling needs a power-of-two period no wider than the code
  if (PERIOD_CYCLES < 2 || PERIOD_CYCLES > (1 << `CODE_WIDTH) ||
      (PERIOD_CYCLES & (PERIOD_CYCLES - 1)) != 0) begin : g_bad_period
    $error("duty_channel: PERIOD_CYCLES must be a power of two in range");
  end

  logic [CW-1:0] cnt;
  logic [CW-1:0] duty;
  wire logic period_end;
  wire logic [CW-1:0] scaled_duty;
  wire logic [CW-1:0] next_cnt;
  wire logic [CW-1:0] next_duty;
  wire logic next_pulse;

  // Duty = code * period / 2**16 truncated; full code range kept, no clamp
  assign scaled_duty = code_in[`CODE_WIDTH-1 -: CW];
  assign period_end = (cnt == LAST);
  assign next_cnt = period_end ? '0 : CW'(cnt + 1'b1);
  // New duty only at a period boundary, so no pulse is cut short
  assign next_duty = period_end ? scaled_duty : duty;
  assign next_pulse = (next_cnt < next_duty);

  // Counter, shadow duty and registered output
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
      duty <= '0;
      pulse_out <= 1'b0;
    end else begin
      cnt <= next_cnt;
      duty <= next_duty;
      pulse_out <= next_pulse;
    end
  end

  sequence s_wrap;
    period_end;
  endsequence

  property p_duty_load;
    @(posedge clk_in) disable iff (!rst_n_in)
    s_wrap |=> (duty == $past(code_in[`CODE_WIDTH-1 -: CW]));
  endproperty
  a_duty_load: assert property (p_duty_load)
    else $error("duty not loaded from code at period end");

  property p_duty_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
    !period_end |=> $stable(duty);
  endproperty
  a_duty_hold: assert property (p_duty_hold)
    else $error("duty changed inside a period");

  property p_pulse_level;
    @(posedge clk_in) disable iff (!rst_n_in)
    ##1 (pulse_out == (cnt < duty));
  endproperty
  a_pulse_level: assert property (p_pulse_level)
    else $error("output level disagrees with counter and duty");

  property p_no_clamp;
    @(posedge clk_in) disable iff (!rst_n_in)
    (s_wrap and (code_in == '1)) |=> (duty == LAST) && pulse_out;
  endproperty
  a_no_clamp: assert property (p_no_clamp)
    else $error("full-scale code was clamped");

endmodule // duty_channel

// ---- verilog/duty_consts.svh ----
// Constants of the dual duty-cycle output block: clock, timing, widths.
// Assumes inclusion by bare name; definitions only.
`ifndef DUTY_CONSTS_SVH
`define DUTY_CONSTS_SVH

// Core clock rate in hertz (100 ns period)
`define CORE_CLK_HZ 10000000
// Measurement interval in milliseconds
`define MEAS_INTERVAL_MS 1000
// Same interval in core clock cycles
`define MEAS_INTERVAL_CYCLES ((`CORE_CLK_HZ / 1000) * `MEAS_INTERVAL_MS)
// Waveform period in core clock cycles, a power of two
`define PWM_PERIOD_CYCLES 4096
// Width of a normalised measurement result; duty fraction = code / 2**16
`define CODE_WIDTH 16
// Receiver decode: percent humidity = offset + span * duty fraction
`define RH_OFFSET_PCT (-6.0)
`define RH_SPAN_PCT 125.0
// Receiver decode: degrees Celsius = offset + span * duty fraction
`define TEMP_OFFSET_C (-46.85)
`define TEMP_SPAN_C 175.72
// Reset values
`define RESET_CODE 16'h0000

`endif

// ---- verilog/duty_pkg.sv ----
// Types shared by the dual duty-cycle output block.
// Assumes duty_consts.svh is on the include path.
`include "duty_consts.svh"

package duty_pkg;

  typedef logic [`CODE_WIDTH-1:0] code_t;

  // One pair of results, taken together once per interval
  typedef struct packed {
    code_t humidity;
    code_t temperature;
  } meas_pair_t;

  // Which measurement the first output carries
  typedef enum logic {
    ASSIGN_TEMP_FIRST,
    ASSIGN_HUM_FIRST
  } assign_t;

endpackage
